/* File: hdl/psr_pkg.sv */
// constants shared by the interrupt steering router, its pci source model and its bench
// assumes one 125 MHz system clock and that every user includes this package
package psr_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int unsigned LINE_CNT = 8; // shared request lines a..h
  localparam int unsigned LEG_CNT = 16; // legacy controller inputs
  localparam int unsigned ADV_CNT = 24; // advanced controller inputs
  localparam int unsigned DYN_CNT = 3; // usb, serial ata, pci express sources
  localparam int unsigned LEG_SEL_W = 4; // width of a legacy irq number
  localparam int unsigned ADV_SEL_W = 5; // width of an advanced irq number
  // ***************************************************
  // fixed legacy irq numbers
  // ***************************************************
  localparam logic [3:0] IRQ_TIMER = 4'h0; // interval timer
  localparam logic [3:0] IRQ_KBD = 4'h1; // keyboard buffer full
  localparam logic [3:0] IRQ_CASCADE = 4'h2; // secondary controller cascade
  localparam logic [3:0] IRQ_SERIAL_DEF = 4'h4; // first serial port default
  localparam logic [3:0] IRQ_FLOPPY = 4'h6; // diskette drive
  localparam logic [3:0] IRQ_PARALLEL_DEF = 4'h7; // first parallel port default
  localparam logic [3:0] IRQ_RTC = 4'h8; // real-time clock
  localparam logic [3:0] IRQ_MOUSE = 4'hc; // on-board mouse port
  localparam logic [3:0] IRQ_FPU = 4'hd; // math coprocessor
  localparam logic [3:0] IRQ_ATA_PRI = 4'he; // primary ata, legacy mode
  localparam logic [3:0] IRQ_ATA_SEC = 4'hf; // secondary ata, legacy mode
  // ***************************************************
  // masks over the sixteen legacy numbers
  // ***************************************************
  // numbers a shared line may select: 3,4,5,6,7,9,10,11,12,14,15
  localparam logic [15:0] STEER_MASK = 16'hdef8;
  // numbers kept free of any fixed on-board source: 3,5,9,10,11
  localparam logic [15:0] FREE_MASK = 16'h0e28;
  // first advanced number driven directly by a shared line
  localparam logic [4:0] ADV_LINE_BASE = 5'h10;
  // reset level of an idle active-low pin
  localparam logic PIN_IDLE = 1'h1;
endpackage : psr_pkg

/* File: hdl/psr_sync.sv */
// two flip-flop synchroniser for a group of asynchronous levels
// assumes the reset is asynchronous and active low; reset value is a constant
module psr_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic RST_VAL = 1'h0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  // ***************************************************
  // stages
  // ***************************************************
  logic [WIDTH-1:0] meta_reg; // first stage, read only by the second

  // two stages back to back
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= {WIDTH{RST_VAL}};
      q_out <= {WIDTH{RST_VAL}};
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule : psr_sync

/* File: hdl/psr_router.sv */
// interrupt steering router: shared pci lines and fixed sources onto the
// legacy 16-input or advanced 24-input controller.
// assumes fixed and dynamic sources come from logic on mclk_in; shared line
// pins are asynchronous, active low and wired-or by the board.
module psr_router
  import psr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic adv_mode_in, // 1: advanced controller, 0: legacy
  input wire logic [psr_pkg::LINE_CNT-1:0] shared_irq_line_n_in, // pins a..h, low = request
  input wire logic [psr_pkg::LINE_CNT-1:0][psr_pkg::LEG_SEL_W-1:0] line_sel_in, // legacy number per line
  input wire logic timer_req_in,
  input wire logic kbd_req_in,
  input wire logic cascade_req_in,
  input wire logic floppy_req_in,
  input wire logic rtc_req_in,
  input wire logic fpu_req_in,
  input wire logic mouse_present_in,
  input wire logic mouse_req_in,
  input wire logic ata_pri_present_in,
  input wire logic ata_pri_req_in,
  input wire logic ata_sec_present_in,
  input wire logic ata_sec_req_in,
  input wire logic serial_req_in, // first serial port
  input wire logic serial_remap_in, // 1: use serial_sel_in if steerable and non-free
  input wire logic [psr_pkg::LEG_SEL_W-1:0] serial_sel_in,
  input wire logic parallel_req_in, // first parallel port
  input wire logic parallel_remap_in,
  input wire logic [psr_pkg::LEG_SEL_W-1:0] parallel_sel_in,
  input wire logic [psr_pkg::DYN_CNT-1:0] dyn_req_in, // usb, sata, pcie
  input wire logic [psr_pkg::DYN_CNT-1:0][psr_pkg::ADV_SEL_W-1:0] dyn_sel_in,
  output logic [psr_pkg::LEG_CNT-1:0] legacy_irq_out,
  output logic [psr_pkg::ADV_CNT-1:0] adv_irq_out
);
  import psr_pkg::*;

  // ***************************************************
  // functions
  // ***************************************************
  // one-hot of a legacy number
  function automatic logic [LEG_CNT-1:0] leg_hot(input logic [LEG_SEL_W-1:0] num);
    leg_hot = {{(LEG_CNT-1){1'b0}}, 1'b1} << num;
  endfunction : leg_hot

  // one-hot of an advanced number, zero when out of range
  function automatic logic [ADV_CNT-1:0] adv_hot(input logic [ADV_SEL_W-1:0] num);
    adv_hot = (num < ADV_SEL_W'(ADV_CNT)) ? ({{(ADV_CNT-1){1'b0}}, 1'b1} << num) : '0;
  endfunction : adv_hot

  // number may be steered to; 12 only while no mouse port
  function automatic logic steer_ok(input logic [LEG_SEL_W-1:0] num, input logic mouse);
    steer_ok = STEER_MASK[num] && !(mouse && num == IRQ_MOUSE);
  endfunction : steer_ok

  // ***************************************************
  // reset and pin synchronisers
  // ***************************************************
  logic rst_n; // released copy of resetn_in
  logic [LINE_CNT-1:0] line_n_sync; // synchronised pins
  logic [LINE_CNT-1:0] line_req; // active-high line requests

  // reset release through two flip-flops
  psr_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_rst_sync (
    .clk_in(mclk_in),
    .rst_n_in(resetn_in),
    .d_in(1'h1),
    .q_out(rst_n)
  );

  psr_sync #(.WIDTH(LINE_CNT), .RST_VAL(PIN_IDLE)) u_line_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(shared_irq_line_n_in),
    .q_out(line_n_sync)
  );

  assign line_req = ~line_n_sync;

  // ***************************************************
  // fixed legacy sources
  // ***************************************************
  logic serial_ok; // remap target usable
  logic parallel_ok;
  logic [LEG_SEL_W-1:0] serial_num; // effective serial number
  logic [LEG_SEL_W-1:0] parallel_num;
  logic [LEG_CNT-1:0] fixed_vec; // fixed sources by number

  // remap only onto steerable, non-free numbers
  assign serial_ok = steer_ok(serial_sel_in, mouse_present_in) && !FREE_MASK[serial_sel_in];
  assign parallel_ok = steer_ok(parallel_sel_in, mouse_present_in) && !FREE_MASK[parallel_sel_in];
  assign serial_num = (serial_remap_in && serial_ok) ? serial_sel_in : IRQ_SERIAL_DEF;
  assign parallel_num = (parallel_remap_in && parallel_ok) ? parallel_sel_in : IRQ_PARALLEL_DEF;

  // reserved numbers wired to their sources
  // nothing fixed on the free numbers
  assign fixed_vec = ({LEG_CNT{timer_req_in}} & leg_hot(IRQ_TIMER))
    | ({LEG_CNT{kbd_req_in}} & leg_hot(IRQ_KBD))
    | ({LEG_CNT{cascade_req_in}} & leg_hot(IRQ_CASCADE))
    | ({LEG_CNT{floppy_req_in}} & leg_hot(IRQ_FLOPPY))
    | ({LEG_CNT{rtc_req_in}} & leg_hot(IRQ_RTC))
    | ({LEG_CNT{fpu_req_in}} & leg_hot(IRQ_FPU))
    | ({LEG_CNT{mouse_present_in && mouse_req_in}} & leg_hot(IRQ_MOUSE))
    | ({LEG_CNT{ata_pri_present_in && ata_pri_req_in}} & leg_hot(IRQ_ATA_PRI))
    | ({LEG_CNT{ata_sec_present_in && ata_sec_req_in}} & leg_hot(IRQ_ATA_SEC))
    | ({LEG_CNT{serial_req_in}} & leg_hot(serial_num))
    | ({LEG_CNT{parallel_req_in}} & leg_hot(parallel_num));

  // ***************************************************
  // steering
  // ***************************************************
  logic [LINE_CNT-1:0][LEG_CNT-1:0] line_hot; // legacy target per line
  logic [DYN_CNT-1:0][LEG_CNT-1:0] dyn_leg_hot; // dynamic sources, legacy
  logic [DYN_CNT-1:0][ADV_CNT-1:0] dyn_adv_hot; // dynamic sources, advanced
  logic [LEG_CNT-1:0] steer_vec; // or of all steered targets
  logic [ADV_CNT-1:0] dyn_adv_vec;

  // one steering slice per shared line
  // card pins arrive pre-wired on the lines
  for (genvar i = 0; i < LINE_CNT; i++) begin : g_line
    // disallowed selections leave the line off
    assign line_hot[i] = (line_req[i] && steer_ok(line_sel_in[i], mouse_present_in)) ? leg_hot(line_sel_in[i]) : '0;
  end

  for (genvar j = 0; j < DYN_CNT; j++) begin : g_dyn
    assign dyn_leg_hot[j] = (dyn_req_in[j] && dyn_sel_in[j] < ADV_SEL_W'(LEG_CNT)
      && steer_ok(dyn_sel_in[j][LEG_SEL_W-1:0], mouse_present_in)) ? leg_hot(dyn_sel_in[j][LEG_SEL_W-1:0]) : '0;
    assign dyn_adv_hot[j] = (dyn_req_in[j] && (dyn_sel_in[j] >= ADV_LINE_BASE
      || steer_ok(dyn_sel_in[j][LEG_SEL_W-1:0], mouse_present_in))) ? adv_hot(dyn_sel_in[j]) : '0;
  end

  always_comb begin
    steer_vec = '0;
    dyn_adv_vec = '0;
    for (int k = 0; k < LINE_CNT; k++) begin
      steer_vec = steer_vec | line_hot[k];
    end
    for (int k = 0; k < DYN_CNT; k++) begin
      steer_vec = steer_vec | dyn_leg_hot[k];
      dyn_adv_vec = dyn_adv_vec | dyn_adv_hot[k];
    end
  end

  // ***************************************************
  // output selection and registers
  // ***************************************************
  logic [LEG_CNT-1:0] legacy_next;
  logic [ADV_CNT-1:0] adv_next;

  // legacy set only in legacy mode
  assign legacy_next = adv_mode_in ? '0 : (fixed_vec | steer_vec);
  // fixed sources low, lines a..h high
  assign adv_next = adv_mode_in ? ({line_req, fixed_vec} | dyn_adv_vec) : '0;

  // output registers
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      legacy_irq_out <= '0;
      adv_irq_out <= '0;
    end else begin
      legacy_irq_out <= legacy_next;
      adv_irq_out <= adv_next;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  logic chk_arm_reg; // high from the first edge at which outputs follow inputs
  logic [LEG_CNT-1:0] share_rest; // legacy requests other than lines a and b
  logic [LEG_CNT-1:0] share_hot; // number selected by line a

  // arm the checks one edge after release; the edge of release still resets the outputs
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      chk_arm_reg <= 1'h0;
    end else begin
      chk_arm_reg <= 1'h1;
    end
  end

  // sources that may share a number with lines a and b
  assign share_rest = fixed_vec | dyn_leg_hot[0] | dyn_leg_hot[1] | dyn_leg_hot[2]
    | line_hot[2] | line_hot[3] | line_hot[4] | line_hot[5] | line_hot[6] | line_hot[7];
  assign share_hot = leg_hot(line_sel_in[0]);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!chk_arm_reg);

  // the synchroniser restarts from idle, so look only two edges after release
  property p_sync_delay;
    $past(rst_n, 2) |-> (line_req == ~$past(shared_irq_line_n_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("line request not two cycles behind pin");

  property p_leg_quiet_adv;
    $past(adv_mode_in) |-> legacy_irq_out == '0;
  endproperty
  a_leg_quiet_adv: assert property (p_leg_quiet_adv) else $error("legacy output active in advanced mode");

  property p_adv_quiet_leg;
    $past(!adv_mode_in) |-> adv_irq_out == '0;
  endproperty
  a_adv_quiet_leg: assert property (p_adv_quiet_leg) else $error("advanced output active in legacy mode");

  property p_adv_direct;
    adv_mode_in ##1 adv_mode_in |-> (~adv_irq_out[ADV_CNT-1:LEG_CNT] & $past(line_req)) == '0;
  endproperty
  a_adv_direct: assert property (p_adv_direct) else $error("shared line missing on its advanced number");

  property p_reserved_fixed;
    !adv_mode_in |=> legacy_irq_out[IRQ_FPU] == $past(fpu_req_in)
      && legacy_irq_out[IRQ_CASCADE] == $past(cascade_req_in)
      && legacy_irq_out[IRQ_RTC] == $past(rtc_req_in);
  endproperty
  a_reserved_fixed: assert property (p_reserved_fixed) else $error("reserved number not tied to its source");

  property p_mouse_owns;
    !adv_mode_in && mouse_present_in |=> legacy_irq_out[IRQ_MOUSE] == $past(mouse_req_in);
  endproperty
  a_mouse_owns: assert property (p_mouse_owns) else $error("irq 12 not owned by present mouse");

  property p_steer_line;
    !adv_mode_in && line_req[0] && steer_ok(line_sel_in[0], mouse_present_in) |=> legacy_irq_out[$past(line_sel_in[0])];
  endproperty
  a_steer_line: assert property (p_steer_line) else $error("line a not steered to its number");

  property p_serial_default;
    !adv_mode_in && serial_req_in && !serial_remap_in |=> legacy_irq_out[IRQ_SERIAL_DEF];
  endproperty
  a_serial_default: assert property (p_serial_default) else $error("serial request missing on default number");

  property p_dyn_adv;
    adv_mode_in && dyn_req_in[0] && dyn_sel_in[0] >= ADV_LINE_BASE && dyn_sel_in[0] < ADV_SEL_W'(ADV_CNT)
      |=> adv_irq_out[$past(dyn_sel_in[0])];
  endproperty
  a_dyn_adv: assert property (p_dyn_adv) else $error("dynamic source missing on programmed number");

  property p_share;
    !adv_mode_in && line_req[0] && line_req[1] && line_sel_in[0] == line_sel_in[1]
      && steer_ok(line_sel_in[0], mouse_present_in)
      |=> legacy_irq_out[$past(line_sel_in[0])]
      && (legacy_irq_out & ~$past(share_rest) & ~$past(share_hot)) == '0;
  endproperty
  a_share: assert property (p_share) else $error("shared lines did not combine");

  c_adv_line: cover property (adv_mode_in && line_req[7]);
  c_leg_shared: cover property (!adv_mode_in && line_req[0] && line_req[1] && line_sel_in[0] == line_sel_in[1]);
  c_serial_remap: cover property (!adv_mode_in && serial_req_in && serial_remap_in && serial_ok);
endmodule : psr_router

/* File: verif/psr_pci_model.sv */
// pci devices and add-in cards raising interrupts on the eight shared lines
// assumes board pull-ups hold a released line high; sources are levels
module psr_pci_model (
  input wire logic [psr_pkg::LINE_CNT-1:0] onboard_req_in, // on-board source per line
  input wire logic [psr_pkg::LINE_CNT-1:0] card_req_in, // card pin wired to each line
  output logic [psr_pkg::LINE_CNT-1:0] shared_irq_line_n_out // pins a..h, low = request
);
  timeunit 1ns;
  timeprecision 100ps;
  import psr_pkg::*;
  // ***************************************************
  // wired sharing
  // ***************************************************
  // wired-or sharing
  // a single-interrupt card uses its first pin; any source pulls low
  assign shared_irq_line_n_out = ~(onboard_req_in | card_req_in);
endmodule : psr_pci_model

/* File: verif/test_psr_router.sv */
// self-checking bench for the interrupt steering router
// assumes the router's package and the pci source model are compiled first
module test_psr_router;
  timeunit 1ns;
  timeprecision 100ps;
  import psr_pkg::*;
  // ***************************************************
  // stimulus and observation
  // ***************************************************
  localparam int LIMIT = 5000; // cycle ceiling for a hang
  localparam int STEER[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15}; // steerable numbers
  localparam int REFUSE[6] = '{0, 1, 2, 8, 13, 12}; // refused selections
  localparam int FIXN[11] = '{0, 1, 2, 6, 8, 13, 12, 14, 15, 4, 7}; // fixed source numbers
  logic mclk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic adv_mode = 1'h0;
  logic [7:0] onb_req = 8'h00; // on-board sources
  logic [7:0] card_req = 8'h00; // card sources
  wire logic [7:0] pins_n; // wired lines from the model
  logic [7:0][3:0] line_sel = '0; // 0 is refused, so lines start unrouted
  logic [10:0] fix_src = 11'h000; // timer..parallel requests, in FIXN order
  logic mouse_p = 1'h0;
  logic ata_p = 1'h0; // both ata channels present
  logic ser_m = 1'h0;
  logic [3:0] ser_s = 4'h0;
  logic par_m = 1'h0;
  logic [3:0] par_s = 4'h0;
  logic [2:0] dyn_r = 3'h0;
  logic [2:0][4:0] dyn_s = '0;
  logic [15:0] leg_o;
  logic [23:0] adv_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // clock, 8 ns period
  always #4 mclk_in = ~mclk_in;
  psr_pci_model model (.onboard_req_in(onb_req), .card_req_in(card_req), .shared_irq_line_n_out(pins_n));
  psr_router dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .adv_mode_in(adv_mode),
    .shared_irq_line_n_in(pins_n), .line_sel_in(line_sel), .timer_req_in(fix_src[0]),
    .kbd_req_in(fix_src[1]), .cascade_req_in(fix_src[2]), .floppy_req_in(fix_src[3]),
    .rtc_req_in(fix_src[4]), .fpu_req_in(fix_src[5]), .mouse_present_in(mouse_p),
    .mouse_req_in(fix_src[6]), .ata_pri_present_in(ata_p), .ata_pri_req_in(fix_src[7]),
    .ata_sec_present_in(ata_p), .ata_sec_req_in(fix_src[8]), .serial_req_in(fix_src[9]),
    .serial_remap_in(ser_m), .serial_sel_in(ser_s), .parallel_req_in(fix_src[10]),
    .parallel_remap_in(par_m), .parallel_sel_in(par_s), .dyn_req_in(dyn_r), .dyn_sel_in(dyn_s),
    .legacy_irq_out(leg_o), .adv_irq_out(adv_o));
  // ***************************************************
  // shared tasks
  // ***************************************************
  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  // compare both outputs as {adv, legacy}
  task automatic cmp(input logic [39:0] exp);
    samples_checked++;
    if ({adv_o, leg_o} !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, {adv_o, leg_o}, exp);
    end
  endtask : cmp
  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // ***************************************************
  // scenarios
  // ***************************************************
  // every steerable number, with the pin-to-output latency
  task automatic t_steer;
    foreach (STEER[k]) begin
      line_sel[k % 8] = 4'(STEER[k]);
      card_req[k % 8] = 1'h1;
      tick(2);
      cmp(40'h0);
      tick(1);
      cmp(40'h1 << STEER[k]);
      card_req[k % 8] = 1'h0;
      line_sel[k % 8] = 4'h0;
      tick(4);
      cmp(40'h0);
    end
  endtask : t_steer
  // reserved numbers and a present mouse refuse a line
  task automatic t_refuse;
    mouse_p = 1'h1;
    card_req[0] = 1'h1;
    foreach (REFUSE[k]) begin
      line_sel[0] = 4'(REFUSE[k]);
      tick(4);
      cmp(40'h0);
    end
    card_req[0] = 1'h0;
    line_sel[0] = 4'h0;
    mouse_p = 1'h0;
    tick(4);
  endtask : t_refuse
  // two sources on line a, then lines a and b on one number
  task automatic t_share;
    line_sel[0] = 4'ha;
    line_sel[1] = 4'ha;
    onb_req[0] = 1'h1;
    card_req[0] = 1'h1;
    tick(4);
    cmp(40'h400);
    onb_req[0] = 1'h0;
    tick(4);
    cmp(40'h400);
    onb_req[1] = 1'h1;
    tick(4);
    cmp(40'h400);
    card_req[0] = 1'h0;
    tick(4);
    cmp(40'h400);
    onb_req[1] = 1'h0;
    tick(4);
    cmp(40'h0);
  endtask : t_share
  // fixed sources, remapping and a programmed dynamic source
  task automatic t_fixed;
    fix_src = 11'h1c0; // mouse and both ata channels, all absent
    tick(2);
    cmp(40'h0);
    mouse_p = 1'h1;
    ata_p = 1'h1;
    foreach (FIXN[k]) begin
      fix_src = 11'h1 << k;
      tick(2);
      cmp(40'h1 << FIXN[k]);
    end
    fix_src = 11'h200;
    ser_m = 1'h1;
    ser_s = 4'h6;
    tick(2);
    cmp(40'h40);
    ser_s = 4'h5;
    tick(2);
    cmp(40'h10);
    fix_src = 11'h400;
    par_m = 1'h1;
    par_s = 4'hf;
    tick(2);
    cmp(40'h8000);
    par_s = 4'h9;
    tick(2);
    cmp(40'h80);
    fix_src = 11'h000;
    dyn_s[1] = 5'h09;
    dyn_r[1] = 1'h1;
    tick(2);
    cmp(40'h200);
    dyn_s[1] = 5'h02;
    tick(2);
    cmp(40'h0);
    dyn_r = 3'h0;
    tick(2);
  endtask : t_fixed
  // advanced mode: lines a..h straight onto 16..23
  task automatic t_adv;
    adv_mode = 1'h1;
    line_sel = {8{4'h5}};
    for (int i = 0; i < 8; i++) begin
      card_req = 8'h1 << i;
      tick(4);
      cmp(40'h1 << (32 + i));
    end
    card_req = 8'h00;
    fix_src[4] = 1'h1;
    tick(4);
    cmp(40'h1 << 24);
    fix_src[4] = 1'h0;
    dyn_s[0] = 5'h14;
    dyn_r[0] = 1'h1;
    tick(2);
    cmp(40'h1 << 36);
    dyn_s[0] = 5'h18;
    tick(2);
    cmp(40'h0);
    dyn_r = 3'h0;
    adv_mode = 1'h0;
    tick(2);
    cmp(40'h0);
  endtask : t_adv
  // reset in mid-run: outputs clear, fixed sources return first, pins last
  task automatic t_reset;
    line_sel[0] = 4'h3;
    card_req[0] = 1'h1;
    fix_src[4] = 1'h1;
    tick(4);
    cmp(40'h108);
    resetn_in = 1'h0;
    tick(1);
    cmp(40'h0);
    resetn_in = 1'h1;
    tick(2);
    cmp(40'h0);
    tick(1);
    cmp(40'h100);
    tick(2);
    cmp(40'h108);
    card_req[0] = 1'h0;
    fix_src[4] = 1'h0;
    tick(4);
    cmp(40'h0);
  endtask : t_reset
  // ***************************************************
  // run control
  // ***************************************************
  // cut a hang short
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    tick(16);
    resetn_in = 1'h1;
    tick(3);
    t_steer();
    t_refuse();
    t_share();
    t_fixed();
    t_adv();
    t_reset();
    stop_test();
  end
endmodule : test_psr_router
